/* File: dv/pdbc_host_model.sv */
// Host bus master that writes messages to the block, 80 ns per bit.
`timescale 1ns/1ns
`default_nettype none
module pdbc_host_model (
	input  wire logic i_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_oe_n
);
	// The bus clock stands high and data is released between messages.
	initial begin
		o_scl = 1'b1;
		o_sda_oe_n = 1'b1;
	end
	// Quarter bit steps, always just after a clock edge.
	task automatic q(input int n);
		repeat (2 * n) @(posedge i_clk);
		#1;
	endtask : q
	task automatic bit_x(input logic b, output logic s);
		q(1);
		o_sda_oe_n = b;
		q(1);
		o_scl = 1'b1;
		q(1);
		s = i_sda;
		q(1);
		o_scl = 1'b0;
	endtask : bit_x
	// Start, address, n data bytes most significant first, stop; counts acknowledges.
	task automatic send(input logic [7:0] addr, input logic [31:0] data, input int n,
		output int acks);
		logic [39:0] bits;
		logic        s;
		bits = {addr, data};
		acks = 0;
		o_sda_oe_n = 1'b0;
		q(1);
		o_scl = 1'b0;
		for (int k = 0; k <= n; k++) begin
			for (int b = 39 - 8 * k; b > 31 - 8 * k; b--) begin
				bit_x(bits[b], s);
			end
			bit_x(1'b1, s);
			acks += int'(!s);
		end
		q(1);
		o_sda_oe_n = 1'b0;
		q(1);
		o_scl = 1'b1;
		q(1);
		o_sda_oe_n = 1'b1;
		q(2);
	endtask : send
endmodule : pdbc_host_model
`default_nettype wire

/* File: dv/pdbc_top_sva.sv */
// Port checker of the divider and band control block.
`timescale 1ns/1ns
`default_nettype none
module pdbc_top_sva
	import pdbc_pkg::*;
(
	input wire logic                  i_clk,
	input wire logic                  i_rst_n,
	input wire logic                  o_sda_oe_n,
	input wire pdbc_pkg::pdbc_ctrl_t  o_ctrl,
	input wire logic                  o_pump_normal,
	input wire logic                  o_amp_disable,
	input wire logic                  o_ref_ratio_long,
	input wire pdbc_pkg::pdbc_level_t o_band_decode_out,
	input wire logic [2:0]            o_band,
	input wire logic [2:0]            o_band_oe_n,
	input wire logic                  o_divider_half_rate,
	input wire logic [14:0]           o_latch_a
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// Decoded outputs are judged only once their source has settled.
	sequence ctrl_held;
		$stable(o_ctrl)[*3];
	endsequence
	sequence band_held;
		$stable(o_band_oe_n)[*3] ##0 !o_ctrl.test_route_select;
	endsequence
	// Each output ties to its control or band bits with the exact mapping.
	pump_map_a: assert property (ctrl_held |-> o_pump_normal == o_ctrl.pump_current_select)
		else $error("pump current does not follow its select bit");
	amp_map_a: assert property (ctrl_held |-> o_amp_disable == o_ctrl.amp_off_bit)
		else $error("amplifier disable does not follow its bit");
	ref_map_a: assert property (ctrl_held |->
		o_ref_ratio_long == (o_ctrl.refdiv_select_a ^ o_ctrl.refdiv_select_b))
		else $error("reference ratio select wrong");
	decode_map_a: assert property (band_held |-> o_band_decode_out == (o_band_oe_n[2] ?
		(o_band_oe_n[0] ? PDBC_LVL_UNDEF : PDBC_LVL_HIGH) :
		(o_band_oe_n[0] ? PDBC_LVL_LOW : PDBC_LVL_MID)))
		else $error("band decoder level wrong");
	// Open-collector buffers may only ever sink.
	band_sink_a: assert property (o_band == 3'h0)
		else $error("band buffer drives high");
	reset_vals_a: assert property (disable iff (1'b0) !i_rst_n |=>
		o_latch_a == 15'h0100 && o_band_oe_n == 3'h7 && o_sda_oe_n)
		else $error("reset values wrong");
	// Ratios of 256 or more keep divider toggles far apart.
	half_gap_a: assert property ($changed(o_divider_half_rate) |=>
		$stable(o_divider_half_rate)[*8])
		else $error("half-rate output toggles too fast");
	ack_hold_a: assert property ($fell(o_sda_oe_n) |=> !o_sda_oe_n[*6])
		else $error("acknowledge too short");
endmodule : pdbc_top_sva
bind pdbc_top pdbc_top_sva i_sva (.i_clk(i_clk), .i_rst_n(i_rst_n), .o_sda_oe_n(o_sda_oe_n),
	.o_ctrl(o_ctrl), .o_pump_normal(o_pump_normal), .o_amp_disable(o_amp_disable),
	.o_ref_ratio_long(o_ref_ratio_long), .o_band_decode_out(o_band_decode_out),
	.o_band(o_band), .o_band_oe_n(o_band_oe_n), .o_divider_half_rate(o_divider_half_rate),
	.o_latch_a(o_latch_a));
`default_nettype wire

/* File: dv/tb_pdbc_top.sv */
// Self-checking bench of the divider and band control block.
`timescale 1ns/1ns
`default_nettype none
module tb_pdbc_top;
	import pdbc_pkg::*;
	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        i_rf_div = 1'b0;
	logic        i_xtal = 1'b0;
	logic        rf_run = 1'b1;
	logic [1:0]  i_addr_sel = 2'h0;
	logic [3:0]  gen_cnt = 4'h0;
	logic        scl, host_oe_n, dut_sda, dut_oe_n, half_rate, pump, amp, ref_long, ref_out;
	logic        gap_sel = 1'b0;
	logic [2:0]  band_oe_n;
	logic [14:0] latch_a;
	logic [7:0]  cb;
	pdbc_level_t dec;
	int          num_errors = 0;
	int          tests_run = 0;
	int          acks, n1, n2;
	pdbc_level_t dec_tab [4] = '{PDBC_LVL_UNDEF, PDBC_LVL_HIGH, PDBC_LVL_LOW, PDBC_LVL_MID};
	// The data line has a pull-up; any party may sink it.
	wire sda_w = (dut_oe_n | dut_sda) & host_oe_n;
	always #5 i_clk = ~i_clk;
	// Prescaled RF at 80 ns and crystal at 40 ns, both launched after the edge.
	always @(posedge i_clk) begin
		gen_cnt <= gen_cnt + 4'h1;
		i_rf_div <= #1 gen_cnt[2] & rf_run;
		i_xtal <= #1 gen_cnt[1];
	end
	pdbc_top i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_scl(scl), .i_sda(sda_w),
		.o_sda(dut_sda), .o_sda_oe_n(dut_oe_n), .i_addr_sel(i_addr_sel), .i_rf_div(i_rf_div),
		.i_xtal(i_xtal), .o_ctrl(), .o_pump_normal(pump), .o_amp_disable(amp),
		.o_ref_ratio_long(ref_long), .o_band_decode_out(dec), .o_band(),
		.o_band_oe_n(band_oe_n), .o_reference_frequency(ref_out), .o_divider_half_rate(half_rate),
		.o_latch_a(latch_a));
	pdbc_host_model i_host (.i_clk(i_clk), .i_sda(sda_w), .o_scl(scl), .o_sda_oe_n(host_oe_n));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("errors %0d comparisons %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop
	// Clocks until the half-rate output, or the reference output while gap_sel is
	// high, next toggles; a stuck divider ends the run.
	task automatic tog_gap(output int n);
		logic h;
		h = gap_sel ? ref_out : half_rate;
		n = 0;
		while ((gap_sel ? ref_out : half_rate) === h) begin
			@(posedge i_clk);
			n++;
			if (n > 9000) begin
				num_errors++;
				report_and_stop();
			end
		end
	endtask : tog_gap
	initial begin
		repeat (16) @(posedge i_clk);
		#1 i_rst_n = 1'b1;
		repeat (8) @(posedge i_clk);
		#1;
		chk(latch_a, 15'h0100);
		chk({band_oe_n, dec}, {3'h7, PDBC_LVL_UNDEF});
		i_host.send(8'hc0, 32'h1234_0000, 2, acks);
		chk(acks, 3);
		chk(latch_a, 15'h1234);
		i_addr_sel = 2'h3;
		// Every band pattern with eight control patterns, control pair first, ratio 300 second.
		for (int i = 0; i < 8; i++) begin
			cb = {1'b1, i[0], 2'b00, i[1], i[2], 1'b1, i[0] ^ i[1]};
			i_host.send(8'hc6, {cb, 1'b0, i[2:0], 4'h0, 16'h012c}, 4, acks);
			chk(acks, 5);
			chk(pump, i[0]);
			chk(amp, i[0] ^ i[1]);
			chk(ref_long, i[1] ^ i[2]);
			chk(band_oe_n, {~i[2], ~i[1], ~i[0]});
			chk(dec, dec_tab[{i[2], i[0]}]);
		end
		tog_gap(n1);
		tog_gap(n1);
		chk(n1, 300 * 8);
		// Equal reference selects: half a period is 256 crystal edges of 4 clocks.
		gap_sel = 1'b1;
		tog_gap(n2);
		tog_gap(n2);
		chk(n2, 256 * 4);
		gap_sel = 1'b0;
		// The reload passes the new ratio on one period late.
		i_host.send(8'hc6, 32'h0100_0000, 2, acks);
		repeat (3) tog_gap(n1);
		chk(n1, 256 * 8);
		// With the divider stalled, a refused message's start still moves the ratio.
		rf_run = 1'b0;
		i_host.send(8'hc6, 32'h0200_0000, 2, acks);
		i_host.send(8'hc0, 32'h0101_0000, 2, acks);
		chk(acks, 0);
		chk(latch_a, 15'h0200);
		rf_run = 1'b1;
		tog_gap(n1);
		tog_gap(n1);
		chk(n1, 512 * 8);
		// Test routing with band bits five and six set, band four off.
		i_host.send(8'hc6, 32'he260_0000, 2, acks);
		n1 = 0;
		n2 = 0;
		cb = {5'h0, band_oe_n};
		repeat (9000) begin
			@(negedge i_clk);
			n1 += int'(band_oe_n[1] !== cb[1]);
			n2 += int'(band_oe_n[2] !== cb[2]);
			cb[2:0] = band_oe_n;
		end
		chk({n1 > 0, n2 > 0, band_oe_n[0]}, 3'h7);
		report_and_stop();
	end
endmodule : tb_pdbc_top
`default_nettype wire

/* File: pkg/pdbc_defines.svh */
// Constants of the tuning-synthesizer divider and band control block.
// How it works
// - Pump bit 0 low current, 1 normal.
// - Band decode uses band bits four, six only.
// - Band buffers open collector, low when bit set.
// - Buffers five, six can carry test signals.
// - Divider counts down, reloads from second latches.
// - Second latches load synchronous to divider output.
// - Any bus start also transfers ratio latches.
// - Ratio is plain binary of fifteen bits.
// - Ratios 256 to 32767 divide correctly.
// - Reset clears receiver, forces ratio bit eight.
// - Amplifier-off bit disables tuning amplifier output.
// - Bit seven picks frequency or control pair.
// - Reference divides 512 if selects equal, else 1024.
// - Test bit routes reference and half rate out, on buffers five, six only when those bits set.
`ifndef PDBC_DEFINES_SVH
`define PDBC_DEFINES_SVH
`define PDBC_RATIO_W        15
`define PDBC_RATIO_RESET    15'h0100
`define PDBC_ADDR_BASE      7'h60
`define PDBC_FUNC_BIT       7
`define PDBC_PUMP_BIT       6
`define PDBC_TEST_BIT       5
`define PDBC_PHASE_B_BIT    4
`define PDBC_REFB_BIT       3
`define PDBC_REFA_BIT       2
`define PDBC_PHASE_A_BIT    1
`define PDBC_AMP_BIT        0
`define PDBC_BAND_HI_BIT    6
`define PDBC_BAND_LO_BIT    4
`define PDBC_CTRL_RESET     8'hc2
`define PDBC_REF_SHORT      11'h200
`define PDBC_REF_LONG       11'h400
`define PDBC_MAX_DATA_BYTES 3'h4
`endif

/* File: pkg/pdbc_pkg.sv */
// Types shared by the divider and band control block.
package pdbc_pkg;
	// Decoder output level for the mixer/oscillator band switch.
	typedef enum logic [1:0] {
		PDBC_LVL_UNDEF,
		PDBC_LVL_LOW,
		PDBC_LVL_MID,
		PDBC_LVL_HIGH
	} pdbc_level_t;

	// Decoded control byte fields.
	typedef struct packed {
		logic       pump_current_select;
		logic       test_route_select;
		logic       refdiv_select_a;
		logic       refdiv_select_b;
		logic [1:0] phase_mode;
		logic       amp_off_bit;
	} pdbc_ctrl_t;

	// Three band bits: high, mid, low.
	typedef struct packed {
		logic band_bit_high;
		logic band_bit_mid;
		logic band_bit_low;
	} pdbc_band_t;
endpackage : pdbc_pkg

/* File: rtl/pdbc_divider.sv */
// Programmable down-counting divider with double-latch ratio reload.
`timescale 1ns/1ns
`default_nettype none
`include "pdbc_defines.svh"
module pdbc_divider #(
	parameter int W = `PDBC_RATIO_W
) (
	// Clock and control.
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_ce,
	// Prescaled input edge and start-condition transfer.
	input  wire logic         i_tick,
	input  wire logic         i_start,
	input  wire logic [W-1:0] i_latch_a,
	// Divider outputs.
	output logic              o_div_pulse,
	output logic              o_half_rate
);
	import pdbc_pkg::*;

	logic [W-1:0] cnt_reg, cnt_next, latch_b_reg, latch_b_next;
	logic         half_reg, half_next, pulse_reg, pulse_next;

	// Count down; at one take the ratio from the second latches.
	always_comb begin
		cnt_next     = cnt_reg;
		latch_b_next = latch_b_reg;
		half_next    = half_reg;
		pulse_next   = 1'b0;
		if (i_tick) begin
			if (cnt_reg <= W'(1)) begin
				// The counter only ever loads from the second latches.
				cnt_next   = latch_b_reg;
				pulse_next = 1'b1;
				half_next  = ~half_reg;
			end else begin
				cnt_next = cnt_reg - W'(1);
			end
		end
		// Transfer in step with the output edge, so the load sees a settled ratio.
		// A bus start moves the ratio as well, even while the divider stands still.
		if (i_tick && cnt_reg <= W'(1)) begin
			latch_b_next = i_latch_a;
		end else if (i_start) begin
			latch_b_next = i_latch_a;
		end
	end

	// Register the divider state.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cnt_reg     <= W'(`PDBC_RATIO_RESET);
			latch_b_reg <= W'(`PDBC_RATIO_RESET);
			half_reg    <= 1'b0;
			pulse_reg   <= 1'b0;
		end else if (i_ce) begin
			cnt_reg     <= cnt_next;
			latch_b_reg <= latch_b_next;
			half_reg    <= half_next;
			pulse_reg   <= pulse_next;
		end
	end

	assign o_div_pulse = pulse_reg;
	assign o_half_rate = half_reg;
endmodule : pdbc_divider
`default_nettype wire

/* File: rtl/pdbc_top.sv */
// Bus receiver, control decode, band buffers and divider of the synthesizer.
`timescale 1ns/1ns
`default_nettype none
`include "pdbc_defines.svh"
module pdbc_top (
	// Clock, reset, clock enable.
	input  wire logic               i_clk,
	input  wire logic               i_rst_n,
	input  wire logic               i_ce,
	// Serial bus pins; sda is open drain.
	input  wire logic               i_scl,
	input  wire logic               i_sda,
	output logic                    o_sda,
	output logic                    o_sda_oe_n,
	// Chip address select, prescaled RF and crystal inputs.
	input  wire logic [1:0]         i_addr_sel,
	input  wire logic               i_rf_div,
	input  wire logic               i_xtal,
	// Control outputs.
	output pdbc_pkg::pdbc_ctrl_t    o_ctrl,
	output logic                    o_pump_normal,
	output logic                    o_amp_disable,
	output logic                    o_ref_ratio_long,
	output pdbc_pkg::pdbc_level_t   o_band_decode_out,
	// Open-collector band buffers, index 0 low, 2 high.
	output logic [2:0]              o_band,
	output logic [2:0]              o_band_oe_n,
	// Internal frequencies.
	output logic                    o_reference_frequency,
	output logic                    o_divider_half_rate,
	output logic [`PDBC_RATIO_W-1:0] o_latch_a
);
	import pdbc_pkg::*;

	typedef enum logic [2:0] {
		PDBC_IDLE,
		PDBC_ADDR,
		PDBC_DATA,
		PDBC_ACK,
		PDBC_SKIP
	} pdbc_state_t;

	// Pin synchronisers; the stage-one flops feed only stage two.
	// The address strap is a pin as well, so it is synchronised like the rest.
	logic [5:0] s1_reg, s2_reg;
	logic [3:0] d_reg;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			s1_reg <= 6'h0f;
			s2_reg <= 6'h0f;
			d_reg  <= 4'hf;
		end else if (i_ce) begin
			s1_reg <= {i_addr_sel, i_xtal, i_rf_div, i_sda, i_scl};
			s2_reg <= s1_reg;
			d_reg  <= s2_reg[3:0];
		end
	end

	logic scl, sda, scl_rise, scl_fall, start, stop, rf_tick, xtal_tick;
	// Edge and bus-condition detection on the settled samples.
	always_comb begin
		scl       = s2_reg[0];
		sda       = s2_reg[1];
		scl_rise  = scl & ~d_reg[0];
		scl_fall  = ~scl & d_reg[0];
		start     = scl & d_reg[0] & d_reg[1] & ~sda;
		stop      = scl & d_reg[0] & ~d_reg[1] & sda;
		rf_tick   = s2_reg[2] & ~d_reg[2];
		xtal_tick = s2_reg[3] & ~d_reg[3];
	end

	pdbc_state_t st_reg, st_next, ret_reg, ret_next;
	logic [3:0]  bit_reg, bit_next;
	logic [2:0]  idx_reg, idx_next;
	logic [7:0]  shf_reg, shf_next, hold_reg, hold_next;
	logic        ack_reg, ack_next;
	pdbc_ctrl_t  ctrl_reg, ctrl_next;
	pdbc_band_t  band_reg, band_next;
	logic [`PDBC_RATIO_W-1:0] lat_reg, lat_next;

	// Receiver: a start always restarts framing, a stop ends it.
	always_comb begin
		st_next   = st_reg;
		ret_next  = ret_reg;
		bit_next  = bit_reg;
		idx_next  = idx_reg;
		shf_next  = shf_reg;
		hold_next = hold_reg;
		ack_next  = ack_reg;
		ctrl_next = ctrl_reg;
		band_next = band_reg;
		lat_next  = lat_reg;
		if (start) begin
			st_next  = PDBC_ADDR;
			bit_next = 4'h0;
			ack_next = 1'b0;
		end else if (stop) begin
			st_next  = PDBC_IDLE;
			ack_next = 1'b0;
		end else begin
			unique case (st_reg)
				PDBC_IDLE, PDBC_SKIP: begin
					ack_next = 1'b0;
				end
				PDBC_ADDR, PDBC_DATA: begin
					if (scl_rise) begin
						shf_next = {shf_reg[6:0], sda};
						bit_next = bit_reg + 4'h1;
					end
					// Eight bits taken: decide whether to acknowledge. The count
					// reaches eight only after real bits, so the clock fall that
					// follows a start is never taken for the end of a byte.
					if (scl_fall && bit_reg == 4'h8 && st_reg == PDBC_ADDR) begin
						if (shf_reg == {(`PDBC_ADDR_BASE | {5'h0, s2_reg[5:4]}), 1'b0}) begin
							ack_next = 1'b1;
							ret_next = PDBC_ADDR;
							st_next  = PDBC_ACK;
							idx_next = 3'h0;
						end else begin
							st_next = PDBC_IDLE;
						end
					end else if (scl_fall && bit_reg == 4'h8) begin
						if (idx_reg < `PDBC_MAX_DATA_BYTES) begin
							ack_next = 1'b1;
							ret_next = PDBC_DATA;
							st_next  = PDBC_ACK;
						end else begin
							st_next = PDBC_SKIP;
						end
					end
				end
				PDBC_ACK: begin
					// Data is acted on only as the acknowledge ends. The address
					// byte is never paired, so the pair count covers data only.
					if (scl_fall) begin
						ack_next = 1'b0;
						st_next  = PDBC_DATA;
						bit_next = 4'h0;
						if (ret_reg == PDBC_DATA) begin
							idx_next = idx_reg + 3'h1;
						end
						if (ret_reg == PDBC_DATA && !idx_reg[0]) begin
							hold_next = shf_reg;
						end else if (ret_reg == PDBC_DATA && hold_reg[`PDBC_FUNC_BIT]) begin
							ctrl_next = '{
								pump_current_select: hold_reg[`PDBC_PUMP_BIT],
								test_route_select:   hold_reg[`PDBC_TEST_BIT],
								refdiv_select_a:     hold_reg[`PDBC_REFA_BIT],
								refdiv_select_b:     hold_reg[`PDBC_REFB_BIT],
								phase_mode:          {hold_reg[`PDBC_PHASE_A_BIT],
								                      hold_reg[`PDBC_PHASE_B_BIT]},
								amp_off_bit:         hold_reg[`PDBC_AMP_BIT]};
							band_next = shf_reg[`PDBC_BAND_HI_BIT:`PDBC_BAND_LO_BIT];
						end else if (ret_reg == PDBC_DATA) begin
							lat_next = {hold_reg[6:0], shf_reg};
						end
					end
				end
			endcase
		end
	end

	// Register the receiver; reset clears it, but loads PDBC_CTRL_RESET into control and 0x0100 into the ratio.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			st_reg   <= PDBC_IDLE;
			ret_reg  <= PDBC_IDLE;
			bit_reg  <= 4'h0;
			idx_reg  <= 3'h0;
			shf_reg  <= 8'h00;
			hold_reg <= 8'h00;
			ack_reg  <= 1'b0;
			ctrl_reg <= pdbc_ctrl_t'(7'(`PDBC_CTRL_RESET));
			band_reg <= '0;
			lat_reg  <= `PDBC_RATIO_RESET;
		end else if (i_ce) begin
			st_reg   <= st_next;
			ret_reg  <= ret_next;
			bit_reg  <= bit_next;
			idx_reg  <= idx_next;
			shf_reg  <= shf_next;
			hold_reg <= hold_next;
			ack_reg  <= ack_next;
			ctrl_reg <= ctrl_next;
			band_reg <= band_next;
			lat_reg  <= lat_next;
		end
	end

	// Reference divider: square wave, period of 512 or 1024 crystal edges.
	logic [10:0] ref_reg, ref_next, ref_ratio;
	logic        refo_reg, refo_next;
	always_comb begin
		ref_ratio = (ctrl_reg.refdiv_select_a == ctrl_reg.refdiv_select_b) ?
		            `PDBC_REF_SHORT : `PDBC_REF_LONG;
		ref_next  = ref_reg;
		refo_next = refo_reg;
		if (xtal_tick) begin
			if (ref_reg >= (ref_ratio >> 1) - 11'h1) begin
				ref_next  = 11'h0;
				refo_next = ~refo_reg;
			end else begin
				ref_next = ref_reg + 11'h1;
			end
		end
	end

	// Register the reference divider.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ref_reg  <= 11'h0;
			refo_reg <= 1'b0;
		end else if (i_ce) begin
			ref_reg  <= ref_next;
			refo_reg <= refo_next;
		end
	end

	logic half_rate;
	pdbc_divider #(.W(`PDBC_RATIO_W)) u_div (
		.i_clk       (i_clk),
		.i_rst_n     (i_rst_n),
		.i_ce        (i_ce),
		.i_tick      (rf_tick),
		.i_start     (start),
		.i_latch_a   (lat_reg),
		.o_div_pulse (),
		.o_half_rate (half_rate)
	);

	// Band buffers conduct while their bit is set; in test mode the
	// signals gate the sink, which only works if the host set the bits.
	logic [2:0] sink;
	always_comb begin
		sink[0] = band_reg.band_bit_low;
		sink[1] = band_reg.band_bit_mid & (~ctrl_reg.test_route_select | ~refo_reg);
		sink[2] = band_reg.band_bit_high & (~ctrl_reg.test_route_select | ~half_rate);
		unique case ({band_reg.band_bit_high, band_reg.band_bit_low})
			2'b10:   o_band_decode_out = PDBC_LVL_LOW;
			2'b11:   o_band_decode_out = PDBC_LVL_MID;
			2'b01:   o_band_decode_out = PDBC_LVL_HIGH;
			2'b00:   o_band_decode_out = PDBC_LVL_UNDEF;
		endcase
	end

	// Output assignments.
	assign o_band                = 3'h0;
	assign o_band_oe_n           = ~sink;
	assign o_sda                 = 1'b0;
	assign o_sda_oe_n            = ~ack_reg;
	assign o_ctrl                = ctrl_reg;
	assign o_pump_normal         = ctrl_reg.pump_current_select;
	assign o_amp_disable         = ctrl_reg.amp_off_bit;
	assign o_ref_ratio_long      = (ref_ratio == `PDBC_REF_LONG);
	assign o_reference_frequency = refo_reg;
	assign o_divider_half_rate   = half_rate;
	assign o_latch_a             = lat_reg;
endmodule : pdbc_top
`default_nettype wire
